//--- bipfu_cfg.svh
// Constants of the binary input pulse/frequency channel.
// Assumes a 100 MHz system clock; values in hundredths of units.
`ifndef BIPFU_CFG_SVH
`define BIPFU_CFG_SVH
// Clock rate and one-second time base
`define BIPFU_CLK_HZ 32'h05f5_e100
`define BIPFU_TICK_S 32'h0000_0001
`define BIPFU_SEC_CYCLES (`BIPFU_TICK_S * `BIPFU_CLK_HZ)
// Full-scale pulse count per gate, as a shift
`define BIPFU_FS_SHIFT 10
`define BIPFU_FS_COUNT 11'h400
// Maximum frequency range and reset value, 0.01 Hz steps
`define BIPFU_FMAX_MIN 32'sh0000_2710
`define BIPFU_FMAX_MAX 32'sh0001_86a0
`define BIPFU_FMAX_RST 17'h1_86a0
// Range values, 0.01 steps
`define BIPFU_LRV_MIN 32'shfffc_f2c0
`define BIPFU_URV_MAX 32'sh000f_4240
`define BIPFU_LRV_RST 32'sh0000_0000
`define BIPFU_URV_RST 32'sh0000_0000
// Damping window in seconds
`define BIPFU_DAMP_MAX 32'sh0000_0258
`define BIPFU_DAMP_RST 10'h000
`define BIPFU_HIST_LAST 10'h257
// Decimal places: reset and largest
`define BIPFU_DP_RST 2'h2
`define BIPFU_DP_MAX 2'h2
// Cleaning cycle length in seconds
`define BIPFU_CLEAN_S 16'h003c
`endif

//--- bipfu_pkg.sv
// Types of the binary input pulse/frequency channel.
// Assumes bipfu_cfg.svh is compiled alongside.
package bipfu_pkg;
  // Static-input application
  typedef enum logic [2:0] {fn_none, fn_range, fn_hold, fn_clean, fn_ctrl} bipfu_func_t;
  // Cleaning sequencer and damper states
  typedef enum logic [0:0] {cln_idle, cln_run} bipfu_cln_t;
  typedef enum logic [1:0] {d_idle, d_acc, d_div} bipfu_dst_t;
  // Channel state
  typedef struct packed {
    logic en;
    logic pulse;
    logic pol_low;
    logic [16:0] fmax;
    logic [1:0] dp;
    logic pmode;
    logic signed [31:0] lrv;
    logic signed [31:0] urv;
    logic [9:0] damp;
    bipfu_func_t func;
    logic bo1_en;
    logic bo2_en;
    logic pin_q;
    logic act;
    logic trig_q;
    logic [47:0] gacc;
    logic [10:0] pcnt;
    logic signed [31:0] raw;
    logic seen;
    logic [31:0] sec;
    logic tick;
    bipfu_cln_t cln;
    logic [15:0] ccnt;
    logic clean;
    logic bo_hold;
    logic bo_clean;
    logic range;
    logic hold;
    logic ctrl;
    logic signed [31:0] value;
    logic [1:0] vdp;
    logic valid;
  } bipfu_chan_t;
  // Damper state
  typedef struct packed {
    bipfu_dst_t st;
    logic [9:0] wp;
    logic [9:0] fill;
    logic signed [41:0] sum;
    logic signed [31:0] cur;
    logic [41:0] q;
    logic [10:0] rem;
    logic [5:0] bits;
    logic neg;
    logic signed [31:0] out;
  } bipfu_dmp_t;
endpackage

//--- bipfu_damper.sv
// Moving-average damper over a window of one-second samples.
// Assumes one smp pulse per second and clr on any reconfiguration.
`timescale 1ns/1ps
`include "bipfu_cfg.svh"
module bipfu_damper (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic smp,
  input wire logic [9:0] win,
  input wire logic signed [31:0] din,
  output logic signed [31:0] dout
);
  bipfu_pkg::bipfu_dmp_t s;
  bipfu_pkg::bipfu_dmp_t nx;
  logic signed [31:0] hist [0:599];
  logic signed [31:0] rd;
  logic [9:0] oidx;
  logic go;

  // Slot written win samples ago
  assign oidx = (s.wp >= win) ? s.wp - win : 10'(s.wp + 10'h258 - win);
  assign go = ce && !clr && s.st == bipfu_pkg::d_idle && smp && win != 10'h000;
  assign dout = s.out;

  // History ring; old value read before overwrite
  always_ff @(posedge clk) begin
    if (go) begin
      hist[s.wp] <= din;
      rd <= hist[oidx];
    end
  end

  // Running sum, then serial divide by sample count
  always_comb begin
    logic [10:0] t;
    logic qb;
    t = '0;
    qb = 1'b0;
    nx = s;
    case (s.st)
      bipfu_pkg::d_idle: begin
        if (win == 10'h000) begin
          nx.out = din;
        end else if (smp) begin
          nx.cur = din;
          nx.st = bipfu_pkg::d_acc;
        end
      end
      bipfu_pkg::d_acc: begin
        nx.sum = s.sum + 42'(s.cur) - ((s.fill == win) ? 42'(rd) : 42'sh000_0000_0000);
        nx.fill = (s.fill < win) ? s.fill + 10'h001 : s.fill;
        nx.wp = (s.wp == `BIPFU_HIST_LAST) ? 10'h000 : s.wp + 10'h001;
        nx.neg = nx.sum < 0;
        nx.q = nx.neg ? 42'(-nx.sum) : 42'(nx.sum);
        nx.rem = '0;
        nx.bits = 6'h2a;
        nx.st = bipfu_pkg::d_div;
      end
      bipfu_pkg::d_div: begin
        t = {s.rem[9:0], s.q[41]};
        if (t >= {1'b0, s.fill}) begin
          nx.rem = t - {1'b0, s.fill};
          qb = 1'b1;
        end else begin
          nx.rem = t;
        end
        nx.q = {s.q[40:0], qb};
        nx.bits = s.bits - 6'h01;
        if (s.bits == 6'h01) begin
          nx.out = s.neg ? -32'(nx.q) : 32'(nx.q);
          nx.st = bipfu_pkg::d_idle;
        end
      end
      default: nx.st = bipfu_pkg::d_idle;
    endcase
    if (clr) begin
      nx.st = bipfu_pkg::d_idle;
      nx.sum = '0;
      nx.fill = '0;
      nx.wp = '0;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{st: bipfu_pkg::d_idle, default: '0};
    end else if (ce) begin
      s <= nx;
    end
  end

  // Checks
  property p_dmp_pass;
    @(posedge clk) disable iff (sys_rst)
    ce && win == 10'h000 && s.st == bipfu_pkg::d_idle |=> dout == $past(din);
  endproperty
  a_dmp_pass: assert property (p_dmp_pass) else $error("undamped value not passed");
  property p_dmp_fill;
    @(posedge clk) disable iff (sys_rst)
    s.fill <= 10'h258 && (s.st != bipfu_pkg::d_div || s.fill != 10'h000);
  endproperty
  a_dmp_fill: assert property (p_dmp_fill) else $error("damper count out of range");
  c_dmp_done: cover property (@(posedge clk) s.st == bipfu_pkg::d_div && s.bits == 6'h01);
endmodule // bipfu_damper

//--- bipfu_channel.sv
// Binary input channel: static level or pulse-rate measurement.
// Assumes pin is synchronous to clk and config writes are single pulses.
`timescale 1ns/1ps
`include "bipfu_cfg.svh"
module bipfu_channel #(
  parameter logic [31:0] SEC_CYCLES = `BIPFU_SEC_CYCLES,
  parameter logic [15:0] CLEAN_S = `BIPFU_CLEAN_S
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [2:0] my_slot,
  input wire logic [1:0] my_input,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_slot,
  input wire logic [1:0] cfg_input,
  input wire logic cfg_in_en,
  input wire logic cfg_pulse,
  input wire logic cfg_pol_low,
  input wire logic [16:0] cfg_fmax,
  input wire logic [1:0] cfg_dp,
  input wire logic cfg_pmode,
  input wire logic signed [31:0] cfg_lrv,
  input wire logic signed [31:0] cfg_urv,
  input wire logic [9:0] cfg_damp,
  input wire bipfu_pkg::bipfu_func_t cfg_func,
  input wire logic cfg_bo_hold_en,
  input wire logic cfg_bo_clean_en,
  input wire logic pin,
  output logic active,
  output logic range_sel,
  output logic hold_ext,
  output logic ctrl_en,
  output logic clean_unit,
  output logic bo_hold,
  output logic bo_clean,
  output logic signed [31:0] value,
  output logic [1:0] value_dp,
  output logic value_valid
);
  // Gate ends when fmax summed per cycle reaches this
  localparam logic [47:0] GATE_TGT = 48'(SEC_CYCLES) * 48'(`BIPFU_FS_COUNT) * 48'h0000_0000_0064;
  localparam bipfu_pkg::bipfu_chan_t RST = '{
    en: 1'b1,
    fmax: `BIPFU_FMAX_RST,
    dp: `BIPFU_DP_RST,
    lrv: `BIPFU_LRV_RST,
    urv: `BIPFU_URV_RST,
    damp: `BIPFU_DAMP_RST,
    func: bipfu_pkg::fn_none,
    bo1_en: 1'b1,
    bo2_en: 1'b1,
    cln: bipfu_pkg::cln_idle,
    vdp: `BIPFU_DP_RST,
    default: '0
  };

  bipfu_pkg::bipfu_chan_t s;
  bipfu_pkg::bipfu_chan_t nx;
  logic acc;
  logic rise;
  logic trig;
  logic signed [31:0] dmp;

  // Limit a setting to its legal span
  function automatic logic signed [31:0] bipfu_clamp(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    bipfu_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Pulse count to frequency or to range-interpolated value
  function automatic logic signed [31:0] bipfu_scale(
    input logic [10:0] cnt,
    input logic [16:0] fm,
    input logic pm,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    logic signed [47:0] span;
    logic signed [47:0] p;
    span = pm ? 48'(hi) - 48'(lo) : $signed(48'(fm));
    p = span * $signed(48'(cnt));
    bipfu_scale = 32'((pm ? 48'(lo) : 48'sh0000_0000_0000) + (p >>> `BIPFU_FS_SHIFT));
  endfunction

  // Drop decimals from a hundredths value
  function automatic logic signed [31:0] bipfu_fmt(
    input logic signed [31:0] v,
    input logic [1:0] dp
  );
    case (dp)
      2'h0: bipfu_fmt = v / 32'sh0000_0064;
      2'h1: bipfu_fmt = v / 32'sh0000_000a;
      default: bipfu_fmt = v;
    endcase
  endfunction

  // Write only reaches the matching slot and input
  assign acc = cfg_wr && cfg_slot == my_slot && cfg_input == my_input;
  assign rise = pin && !s.pin_q;
  assign trig = s.act && s.func == bipfu_pkg::fn_clean;

  // Next-state logic
  always_comb begin
    nx = s;
    nx.pin_q = pin;
    // Static level with polarity; silent when off or pulsed
    nx.act = s.en && !s.pulse && (s.pin_q ^ s.pol_low);
    nx.range = nx.act && s.func == bipfu_pkg::fn_range;
    nx.hold = nx.act && s.func == bipfu_pkg::fn_hold;
    nx.ctrl = nx.act && s.func == bipfu_pkg::fn_ctrl;
    // Gate length 1024/fmax seconds; count saturates at full scale
    if (s.en && s.pulse) begin
      if (s.gacc + 48'(s.fmax) >= GATE_TGT) begin
        nx.gacc = s.gacc + 48'(s.fmax) - GATE_TGT;
        nx.raw = bipfu_scale(s.pcnt, s.fmax, s.pmode, s.lrv, s.urv);
        nx.pcnt = {10'h000, rise};
        nx.seen = 1'b1;
      end else begin
        nx.gacc = s.gacc + 48'(s.fmax);
        if (rise && s.pcnt < `BIPFU_FS_COUNT) begin
          nx.pcnt = s.pcnt + 11'h001;
        end
      end
    end
    // One-second time base for damping and cleaning
    if (s.sec >= SEC_CYCLES - 32'h0000_0001) begin
      nx.sec = '0;
      nx.tick = 1'b1;
    end else begin
      nx.sec = s.sec + 32'h0000_0001;
      nx.tick = 1'b0;
    end
    // Cleaning cycle on trigger edge
    nx.trig_q = trig;
    case (s.cln)
      bipfu_pkg::cln_idle: begin
        if (trig && !s.trig_q) begin
          nx.cln = bipfu_pkg::cln_run;
          nx.ccnt = CLEAN_S;
        end
      end
      bipfu_pkg::cln_run: begin
        if (s.tick) begin
          if (s.ccnt <= 16'h0001) begin
            nx.cln = bipfu_pkg::cln_idle;
            nx.ccnt = '0;
          end else begin
            nx.ccnt = s.ccnt - 16'h0001;
          end
        end
      end
      default: nx.cln = bipfu_pkg::cln_idle;
    endcase
    // Configuration write restarts measurement
    if (acc) begin
      nx.en = cfg_in_en;
      nx.pulse = cfg_pulse;
      nx.pol_low = cfg_pol_low;
      nx.fmax = 17'(bipfu_clamp(32'(cfg_fmax), `BIPFU_FMAX_MIN, `BIPFU_FMAX_MAX));
      nx.dp = (cfg_dp > `BIPFU_DP_MAX) ? `BIPFU_DP_MAX : cfg_dp;
      nx.pmode = cfg_pmode;
      nx.lrv = bipfu_clamp(cfg_lrv, `BIPFU_LRV_MIN, 32'sh0000_0000);
      nx.urv = bipfu_clamp(cfg_urv, 32'sh0000_0000, `BIPFU_URV_MAX);
      nx.damp = 10'(bipfu_clamp(32'(cfg_damp), 32'sh0000_0000, `BIPFU_DAMP_MAX));
      nx.func = cfg_func;
      nx.bo1_en = cfg_bo_hold_en;
      nx.bo2_en = cfg_bo_clean_en;
      nx.gacc = '0;
      // Keep this cycle's edge so the first gate is full length
      nx.pcnt = {10'h000, rise};
      nx.seen = 1'b0;
      nx.raw = cfg_pmode ? nx.lrv : 32'sh0000_0000;
    end
    // Forwarded cleaning, each output gated by its enable
    nx.clean = nx.cln == bipfu_pkg::cln_run;
    nx.bo_hold = nx.clean && nx.bo1_en;
    nx.bo_clean = nx.clean && nx.bo2_en;
    // Damped value, formatted; zero unless measuring
    nx.valid = s.en && s.pulse && s.seen;
    nx.value = nx.valid ? bipfu_fmt(dmp, s.dp) : 32'sh0000_0000;
    nx.vdp = s.dp;
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= RST;
    end else if (ce) begin
      s <= nx;
    end
  end

  // Moving average of the measured value
  bipfu_damper bipfu_damper_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .clr(acc || !s.en || !s.pulse),
    .smp(s.tick),
    .win(s.damp),
    .din(s.raw),
    .dout(dmp)
  );

  // Outputs
  assign active = s.act;
  assign range_sel = s.range;
  assign hold_ext = s.hold;
  assign ctrl_en = s.ctrl;
  assign clean_unit = s.clean;
  assign bo_hold = s.bo_hold;
  assign bo_clean = s.bo_clean;
  assign value = s.value;
  assign value_dp = s.vdp;
  assign value_valid = s.valid;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_off_quiet;
    ce && !s.en |=> value == 32'sh0000_0000 && !value_valid && !active;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled channel drives");
  property p_pulse_no_level;
    ce && s.pulse && !acc ##1 ce |=> !active && !range_sel && !hold_ext && !ctrl_en;
  endproperty
  a_pulse_no_level: assert property (p_pulse_no_level) else $error("level seen in pulse mode");
  property p_polarity;
    ce && s.en && !s.pulse && !acc ##1 ce |=> active == ($past(pin, 2) ^ $past(s.pol_low));
  endproperty
  a_polarity: assert property (p_polarity) else $error("static level polarity wrong");
  property p_app;
    range_sel |-> active && $past(s.func) == bipfu_pkg::fn_range;
  endproperty
  a_app: assert property (p_app) else $error("range switch without active input");
  property p_sat;
    s.pcnt <= `BIPFU_FS_COUNT;
  endproperty
  a_sat: assert property (p_sat) else $error("pulse count above full scale");
  property p_freq_span;
    s.en && !s.pmode |-> s.raw >= 32'sh0000_0000 && s.raw <= $signed(32'(s.fmax));
  endproperty
  a_freq_span: assert property (p_freq_span) else $error("frequency above maximum");
  property p_param_span;
    s.en && s.pmode |-> s.raw >= s.lrv && s.raw <= s.lrv + (s.urv - s.lrv);
  endproperty
  a_param_span: assert property (p_param_span) else $error("value outside range values");
  property p_addr;
    ce && cfg_wr && !acc |=> $stable(s.fmax) && $stable(s.en) && $stable(s.damp);
  endproperty
  a_addr: assert property (p_addr) else $error("write to other channel changed config");
  property p_clean_start;
    ce && trig && !s.trig_q && s.cln == bipfu_pkg::cln_idle && !acc |=> clean_unit;
  endproperty
  a_clean_start: assert property (p_clean_start) else $error("cleaning not started");
  property p_bo_gate;
    ce && acc |=> (bo_hold == (clean_unit && $past(cfg_bo_hold_en))) &&
      (bo_clean == (clean_unit && $past(cfg_bo_clean_en)));
  endproperty
  a_bo_gate: assert property (p_bo_gate) else $error("forwarded cleaning output wrong");
  property p_dp;
    value_valid && value_dp == 2'h0 |-> value == $past(dmp) / 32'sh0000_0064;
  endproperty
  a_dp: assert property (p_dp) else $error("decimal format wrong");

  c_gate: cover property (s.en && s.pulse && s.seen && s.pcnt == `BIPFU_FS_COUNT);
  c_clean: cover property (bo_hold && bo_clean);
  c_param: cover property (value_valid && s.pmode && s.raw > 32'sh0000_0000);
endmodule // bipfu_channel

//--- bipfu_field_model.sv
// Field side of one binary input: pulse source or plain switch,
// plus a receiving instrument on the two forwarded binary outputs.
// Assumes clk is the bench clock; pin moves just after rising edges.
`timescale 1ns/1ps
module bipfu_field_model (
  input wire logic clk,
  input wire logic [7:0] half,
  input wire logic level,
  input wire logic bo_hold,
  input wire logic bo_clean,
  output logic pin,
  output logic rx_hold,
  output logic rx_clean
);
  logic [7:0] cnt = 8'h00;
  logic tog = 1'b0;
  // Pulse train toggles every half period; zero means a steady switch
  always @(posedge clk) begin
    if (half == 8'h00) begin
      cnt <= 8'h00;
      tog <= 1'b0;
    end else if (cnt + 8'h01 >= half) begin
      cnt <= 8'h00;
      tog <= ~tog;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign pin = (half == 8'h00) ? level : tog;
  // Receiver without cleaning unit holds its sensors while forwarded
  assign rx_hold = bo_hold;
  // Receiver with own cleaning units starts along with the master
  assign rx_clean = bo_clean;
endmodule // bipfu_field_model

//--- tb_binary_input_pulse_frequency_unit.sv
// Self-checking bench for one binary input channel and its field side.
// Assumes bipfu_pkg, bipfu_channel and bipfu_field_model are compiled.
`timescale 1ns/1ps
module tb_binary_input_pulse_frequency_unit;
  logic clk, sys_rst, ce, cfg_wr, cfg_in_en, cfg_pulse, cfg_pol_low, cfg_pmode;
  logic cfg_bo_hold_en, cfg_bo_clean_en, pin, lvl, rx_hold, rx_clean;
  logic active, range_sel, hold_ext, ctrl_en, clean_unit, bo_hold, bo_clean, value_valid;
  logic [2:0] cfg_slot;
  logic [1:0] cfg_input, cfg_dp, value_dp;
  logic [16:0] cfg_fmax;
  logic [9:0] cfg_damp;
  logic [7:0] half;
  logic signed [31:0] cfg_lrv, cfg_urv, value;
  bipfu_pkg::bipfu_func_t cfg_func;
  bipfu_pkg::bipfu_func_t fl [3];
  int err_count = 0;
  int n_compared = 0;
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  bipfu_channel #(.SEC_CYCLES(32'h0000_00c8), .CLEAN_S(16'h0002)) bipfu_channel_inst (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .my_slot(3'h5), .my_input(2'h1),
    .cfg_wr(cfg_wr), .cfg_slot(cfg_slot), .cfg_input(cfg_input), .cfg_in_en(cfg_in_en),
    .cfg_pulse(cfg_pulse), .cfg_pol_low(cfg_pol_low), .cfg_fmax(cfg_fmax), .cfg_dp(cfg_dp),
    .cfg_pmode(cfg_pmode), .cfg_lrv(cfg_lrv), .cfg_urv(cfg_urv), .cfg_damp(cfg_damp),
    .cfg_func(cfg_func), .cfg_bo_hold_en(cfg_bo_hold_en), .cfg_bo_clean_en(cfg_bo_clean_en),
    .pin(pin), .active(active), .range_sel(range_sel), .hold_ext(hold_ext),
    .ctrl_en(ctrl_en), .clean_unit(clean_unit), .bo_hold(bo_hold), .bo_clean(bo_clean),
    .value(value), .value_dp(value_dp), .value_valid(value_valid)
  );
  bipfu_field_model bipfu_field_model_inst (
    .clk(clk), .half(half), .level(lvl), .bo_hold(bo_hold), .bo_clean(bo_clean),
    .pin(pin), .rx_hold(rx_hold), .rx_clean(rx_clean)
  );
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic nwait(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Field side: pulse half period (zero is steady) and switch level
  task automatic drive(input logic [7:0] h, input logic l);
    @(posedge clk);
    half <= h;
    lvl <= l;
  endtask
  // One whole configuration write to address adr
  task automatic cfg(input logic [4:0] adr, input logic en, input logic pls, input logic pol,
      input logic [16:0] fm, input logic [1:0] dp, input logic pmd, input logic [9:0] dmp,
      input bipfu_pkg::bipfu_func_t fn, input logic bh, input logic bc);
    @(posedge clk);
    {cfg_slot, cfg_input} <= adr;
    cfg_in_en <= en;
    cfg_pulse <= pls;
    cfg_pol_low <= pol;
    cfg_fmax <= fm;
    cfg_dp <= dp;
    cfg_pmode <= pmd;
    cfg_damp <= dmp;
    cfg_func <= fn;
    cfg_bo_hold_en <= bh;
    cfg_bo_clean_en <= bc;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  // Pulse mode: set rate, restart gate, wait first result
  task automatic meas(input logic [7:0] h, input logic [16:0] fm, input logic [1:0] dp,
      input logic pmd, input logic [9:0] dmp, input logic [31:0] exp);
    int k;
    k = 0;
    drive(h, 1'b0);
    cfg(5'h15, 1'b1, 1'b1, 1'b0, fm, dp, pmd, dmp, bipfu_pkg::fn_none, 1'b1, 1'b1);
    nwait(2);
    while (value_valid !== 1'b1 && k < 3000) begin
      nwait(1);
      k++;
    end
    nwait(2);
    check({31'h0, value_valid}, 32'h0000_0001);
    check({30'h0, value_dp}, {30'h0, dp});
    check(value, exp);
  endtask
  // Hang guard well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    fl = '{bipfu_pkg::fn_range, bipfu_pkg::fn_hold, bipfu_pkg::fn_ctrl};
    sys_rst = 1'b1;
    ce = 1'b1;
    cfg_wr = 1'b0;
    {cfg_slot, cfg_input} = 5'h15;
    {cfg_in_en, cfg_pulse, cfg_pol_low, cfg_pmode} = 4'h8;
    {cfg_bo_hold_en, cfg_bo_clean_en} = 2'h3;
    cfg_fmax = 17'h1_86a0;
    cfg_dp = 2'h2;
    cfg_lrv = 32'hffff_d8f0;
    cfg_urv = 32'h0000_7530;
    cfg_damp = 10'h000;
    cfg_func = bipfu_pkg::fn_none;
    half = 8'h00;
    lvl = 1'b0;
    repeat (16) @(posedge clk);
    nwait(1);
    check({30'h0, value_dp}, 32'h0000_0002);
    check({28'h0, active, clean_unit, value_valid, bo_hold}, 32'h0000_0000);
    @(posedge clk);
    sys_rst <= 1'b0;
    // Defaults: on, static, high active, two cycles of latency
    drive(8'h00, 1'b1);
    nwait(2);
    check({31'h0, active}, 32'h0000_0000);
    nwait(1);
    check({31'h0, active}, 32'h0000_0001);
    check({29'h0, range_sel, hold_ext, ctrl_en}, 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b0;
    lvl <= 1'b0;
    nwait(4);
    check({31'h0, active}, 32'h0000_0001);
    @(posedge clk);
    ce <= 1'b1;
    nwait(3);
    check({31'h0, active}, 32'h0000_0000);
    $display("test static defaults done");
    // Range, hold and control static applications
    drive(8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      cfg(5'h15, 1'b1, 1'b0, 1'b0, 17'h1_86a0, 2'h2, 1'b0, 10'h000, fl[i], 1'b1, 1'b1);
      nwait(3);
      check({29'h0, range_sel, hold_ext, ctrl_en}, 32'h0000_0004 >> i);
    end
    // Low polarity, addressing, channel off, pulse mode silences static
    cfg(5'h15, 1'b1, 1'b0, 1'b1, 17'h1_86a0, 2'h2, 1'b0, 10'h000, fl[0], 1'b1, 1'b1);
    nwait(3);
    check({31'h0, active}, 32'h0000_0000);
    drive(8'h00, 1'b0);
    nwait(3);
    check({30'h0, active, range_sel}, 32'h0000_0003);
    cfg(5'h14, 1'b0, 1'b0, 1'b1, 17'h1_86a0, 2'h2, 1'b0, 10'h000, fl[0], 1'b1, 1'b1);
    cfg(5'h0d, 1'b0, 1'b0, 1'b1, 17'h1_86a0, 2'h2, 1'b0, 10'h000, fl[0], 1'b1, 1'b1);
    nwait(3);
    check({31'h0, active}, 32'h0000_0001);
    cfg(5'h15, 1'b0, 1'b0, 1'b1, 17'h1_86a0, 2'h2, 1'b0, 10'h000, fl[0], 1'b1, 1'b1);
    nwait(3);
    check({30'h0, active, range_sel}, 32'h0000_0000);
    cfg(5'h15, 1'b1, 1'b1, 1'b1, 17'h1_86a0, 2'h2, 1'b0, 10'h000, fl[0], 1'b1, 1'b1);
    nwait(3);
    check({30'h0, active, range_sel}, 32'h0000_0000);
    $display("test static options done");
    // Cleaning trigger, forwarding, retrigger ignored, bounded length
    cfg(5'h15, 1'b1, 1'b0, 1'b0, 17'h1_86a0, 2'h2, 1'b0, 10'h000, bipfu_pkg::fn_clean, 1'b1, 1'b1);
    nwait(3);
    drive(8'h00, 1'b1);
    nwait(3);
    check({31'h0, clean_unit}, 32'h0000_0000);
    nwait(1);
    check({27'h0, clean_unit, bo_hold, bo_clean, rx_hold, rx_clean}, 32'h0000_001f);
    nwait(100);
    drive(8'h00, 1'b0);
    nwait(5);
    drive(8'h00, 1'b1);
    nwait(85);
    check({31'h0, clean_unit}, 32'h0000_0001);
    nwait(220);
    check({29'h0, clean_unit, bo_hold, bo_clean}, 32'h0000_0000);
    drive(8'h00, 1'b0);
    cfg(5'h15, 1'b1, 1'b0, 1'b0, 17'h1_86a0, 2'h2, 1'b0, 10'h000, bipfu_pkg::fn_clean, 1'b0, 1'b0);
    nwait(3);
    drive(8'h00, 1'b1);
    nwait(4);
    check({29'h0, clean_unit, bo_hold, bo_clean}, 32'h0000_0004);
    nwait(420);
    $display("test cleaning done");
    // Pulse rate: saturation, clamp, format, parameter range ends
    meas(8'h01, 17'h0_2710, 2'h2, 1'b0, 10'h000, 32'h0000_2710);
    meas(8'h02, 17'h0_2710, 2'h2, 1'b0, 10'h000, 32'h0000_1388);
    meas(8'h01, 17'h0_1388, 2'h2, 1'b0, 10'h000, 32'h0000_2710);
    meas(8'h02, 17'h0_2710, 2'h0, 1'b0, 10'h000, 32'h0000_0032);
    meas(8'h02, 17'h0_2710, 2'h1, 1'b0, 10'h000, 32'h0000_01f4);
    meas(8'h02, 17'h0_2710, 2'h2, 1'b1, 10'h000, 32'h0000_2710);
    meas(8'h00, 17'h0_2710, 2'h2, 1'b1, 10'h000, 32'hffff_d8f0);
    meas(8'h01, 17'h0_2710, 2'h2, 1'b1, 10'h000, 32'h0000_7530);
    $display("test pulse rate done");
    // Damping: a rate step is smoothed over three one-second samples
    @(posedge clk);
    cfg_lrv <= 32'h0000_0000;
    // Window still holds only samples taken before the first gate ended
    meas(8'h02, 17'h0_2710, 2'h2, 1'b0, 10'h003, 32'h0000_0000);
    drive(8'h04, 1'b0);
    nwait(2050);
    check({31'h0, value > 32'sh0000_09d8}, 32'h0000_0001);
    nwait(1000);
    check({31'h0, value >= 32'sh0000_09c4 && value <= 32'sh0000_09ce}, 32'h0000_0001);
    $display("test damping done");
    complete_run();
  end
endmodule // tb_binary_input_pulse_frequency_unit
